// *** rtl/prox_ref_startup.sv ***
/*
  Reference-phase correction and start-up proximity detection, one update
  per scan sample, with its registers. Assumes a decoded register port and
  samples, compensation events and freeze status, all on clk_sys.
*/
// How it works
// - calibration value in two reset-cleared bytes
// - enable low passes every phase unchanged
// - enable high corrects others from reference phase
// - method 1 rebuilds frozen average from drift
// - snapshots taken when average becomes frozen
// - two-bit field selects reference phase
// - baseline from calibration or current reference value
// - coefficient is unsigned three-dot-five fixed point
// - one coefficient per phase pair
// - method 0 coefficient scaled by raw filter
// - two-bit start-up phase select, default one
// - frequency bit: phase-enable or every compensation
// - method 0 compares offset, then useful value
// - method 0 sets status above threshold
// - method 0 clears status below threshold
// - method 1 forces offset, freezes average
// - failed start-up clears status, restores offset
// - start-up uses corrected useful values
// - nonzero offset threshold enables start-up
`timescale 1ns/10ps
`default_nettype none
`include "prox_ref_consts.svh"
module prox_ref_startup
  import prox_ref_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic         regWrite,
  input  wire logic [7:0]   regAddr,
  input  wire logic [7:0]   regWdata,
  output logic      [7:0]   regRdata,
  input  wire logic         sampleValid,
  input  wire sample_t      sampleIn,
  input  wire logic         compDone,
  input  wire logic         compFromPhaseEnable,
  input  wire logic [2:0]   rawFilter,
  input  wire logic         avgFrozen,
  input  wire logic         usefulThreshEnable,
  input  wire logic [15:0]  usefulThreshold,
  output sample_t           sampleOut,
  output logic              sampleOutValid,
  output logic              proximityStatus,
  output logic              offsetForce,
  output logic      [5:0]   offsetForceValue,
  output logic              avgHold,
  output logic              compRequest
);
  logic [7:0] calHigh_r, calLow_r, ctrl_r, coefLow_r, coefHigh_r, suCtrl_r, offThr_r;
  logic [7:0] calHigh_nxt, calLow_nxt, ctrl_nxt, coefLow_nxt, coefHigh_nxt;
  logic [7:0] suCtrl_nxt, offThr_nxt;
  // register file
  always_comb begin
    calHigh_nxt  = calHigh_r;
    calLow_nxt   = calLow_r;
    ctrl_nxt     = ctrl_r;
    coefLow_nxt  = coefLow_r;
    coefHigh_nxt = coefHigh_r;
    suCtrl_nxt   = suCtrl_r;
    offThr_nxt   = offThr_r;
    if (regWrite) begin
      case (regAddr)
        `OFS_REF_CAL_HIGH:   calHigh_nxt = regWdata;
        `OFS_REF_CAL_LOW:    calLow_nxt = regWdata;
        `OFS_REF_CTRL:       ctrl_nxt = {3'h0, regWdata[4:0]};
        `OFS_COEF_LOW_PAIR:  coefLow_nxt = regWdata;
        `OFS_COEF_HIGH_PAIR: coefHigh_nxt = regWdata;
        `OFS_STARTUP_CTRL:   suCtrl_nxt = {4'h0, regWdata[3:0]};
        `OFS_OFFSET_THRESH:  offThr_nxt = {2'h0, regWdata[5:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      calHigh_r  <= `RST_REF_CAL;
      calLow_r   <= `RST_REF_CAL;
      ctrl_r     <= `RST_REF_CTRL;
      coefLow_r  <= `RST_COEF;
      coefHigh_r <= `RST_COEF;
      suCtrl_r   <= `RST_STARTUP_CTRL;
      offThr_r   <= `RST_OFFSET_THRESH;
    end else begin
      calHigh_r  <= calHigh_nxt;
      calLow_r   <= calLow_nxt;
      ctrl_r     <= ctrl_nxt;
      coefLow_r  <= coefLow_nxt;
      coefHigh_r <= coefHigh_nxt;
      suCtrl_r   <= suCtrl_nxt;
      offThr_r   <= offThr_nxt;
    end
  end

  always_comb begin
    case (regAddr)
      `OFS_REF_CAL_HIGH:   regRdata = calHigh_r;
      `OFS_REF_CAL_LOW:    regRdata = calLow_r;
      `OFS_REF_CTRL:       regRdata = ctrl_r;
      `OFS_COEF_LOW_PAIR:  regRdata = coefLow_r;
      `OFS_COEF_HIGH_PAIR: regRdata = coefHigh_r;
      `OFS_STARTUP_CTRL:   regRdata = suCtrl_r;
      `OFS_OFFSET_THRESH:  regRdata = offThr_r;
      default:             regRdata = 8'h00;
    endcase
  end

  logic       ref_correct_enable, ref_correct_method, ref_baseline_init, suFreq, suMethod, suEnabled;
  logic [1:0] ref_phase_select, suPhase;
  logic [5:0] offThr;
  assign ref_correct_enable     = ctrl_r[`BIT_REF_EN];
  assign ref_correct_method = ctrl_r[`BIT_REF_METHOD];
  assign ref_phase_select  = ctrl_r[`POS_REF_PHASE +: 2];
  assign ref_baseline_init   = ctrl_r[`BIT_REF_INIT];
  assign suPhase   = suCtrl_r[`POS_STARTUP_PHASE +: 2];
  assign suFreq    = suCtrl_r[`BIT_STARTUP_FREQ];
  assign suMethod  = suCtrl_r[`BIT_STARTUP_METHOD];
  assign offThr    = offThr_r[5:0];
  assign suEnabled = (offThr != 6'h00);
  // correction datapath
  logic signed [15:0] refLast_r, refLast_nxt, refBase_r, refBase_nxt;
  logic signed [15:0] frozenRef_r, frozenRef_nxt;
  logic signed [15:0] frozenAvg_r [4];
  logic signed [15:0] frozenAvg_nxt [4];
  logic [3:0]         snapPending_r, snapPending_nxt;
  logic               frozenPrev_r;
  logic [5:0]         suOffset_r, suOffset_nxt;
  logic [7:0]         coef, coefEff;
  logic signed [16:0] drift;
  logic signed [25:0] scaled;
  logic signed [15:0] corrUseful, corrAvg;
  logic               isRef, isSu;
  logic signed [15:0] curRef;
  assign isRef  = (sampleIn.phase == ref_phase_select);
  assign isSu   = (sampleIn.phase == suPhase);
  assign curRef = (sampleValid && isRef) ? sampleIn.useful : refLast_r;
  assign coef   = sampleIn.phase[1] ? coefHigh_r : coefLow_r;
  // method 0 trims the gain by the raw filter so filtered drift is not overcorrected
  assign coefEff = (!ref_correct_method && rawFilter != 3'h0) ?
                   coef - (coef >> rawFilter) : coef;
  assign drift  = ref_correct_method ? 17'(curRef) - 17'(frozenRef_r)
                            : 17'(curRef) - 17'(refBase_r);
  // unsigned 3.5 coefficient times signed drift, back to integer scale
  assign scaled = ($signed({1'b0, coefEff}) * drift) >>> `COEF_FRAC_BITS;
  always_comb begin
    corrUseful = sampleIn.useful;
    corrAvg    = sampleIn.average;
    if (ref_correct_enable && !isRef) begin
      if (!ref_correct_method) begin
        corrUseful = 16'(26'(sampleIn.useful) - scaled);
      // a sample in the freezing cycle is its own snapshot, so it passes raw
      end else if (avgFrozen && frozenPrev_r && !snapPending_r[sampleIn.phase]) begin
        corrAvg = 16'(26'(frozenAvg_r[sampleIn.phase]) + scaled);
      end
    end
  end

  always_comb begin
    refLast_nxt     = curRef;
    refBase_nxt     = refBase_r;
    frozenRef_nxt   = frozenRef_r;
    frozenAvg_nxt   = frozenAvg_r;
    snapPending_nxt = snapPending_r;
    suOffset_nxt    = suOffset_r;
    if (sampleValid && isSu) begin
      suOffset_nxt = sampleIn.offset;
    end
    if (compDone) begin
      if (!ref_baseline_init && suEnabled && suOffset_r == offThr) begin
        refBase_nxt = $signed({calHigh_r, calLow_r});
      end else begin
        refBase_nxt = curRef;
      end
    end
    if (avgFrozen && !frozenPrev_r) begin
      frozenRef_nxt   = curRef;
      snapPending_nxt = 4'hF;
    end
    if (sampleValid && snapPending_nxt[sampleIn.phase]) begin
      frozenAvg_nxt[sampleIn.phase]   = sampleIn.average;
      snapPending_nxt[sampleIn.phase] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      refLast_r     <= 16'sh0000;
      refBase_r     <= 16'sh0000;
      frozenRef_r   <= 16'sh0000;
      frozenAvg_r   <= '{default: 16'sh0000};
      snapPending_r <= 4'h0;
      frozenPrev_r  <= 1'b0;
      suOffset_r    <= 6'h00;
    end else begin
      refLast_r     <= refLast_nxt;
      refBase_r     <= refBase_nxt;
      frozenRef_r   <= frozenRef_nxt;
      frozenAvg_r   <= frozenAvg_nxt;
      snapPending_r <= snapPending_nxt;
      frozenPrev_r  <= avgFrozen;
      suOffset_r    <= suOffset_nxt;
    end
  end
  // start-up detection
  su_state_t  state_r, state_nxt;
  logic       prox_r, prox_nxt, first_r, first_nxt, compReq_nxt, compReq_r;
  logic       uAbove, uBelow;
  logic       suEval;
  // decisions look at the corrected value, never the raw one
  assign uAbove = $signed(corrUseful) > $signed(usefulThreshold);
  assign uBelow = $signed(corrUseful) < $signed(usefulThreshold);
  assign suEval = sampleValid && isSu;

  always_comb begin
    state_nxt   = state_r;
    prox_nxt    = prox_r;
    first_nxt   = first_r;
    compReq_nxt = 1'b0;
    case (state_r)
      SU_IDLE: begin
        if (compDone && suEnabled && (suFreq || compFromPhaseEnable)) begin
          state_nxt = suMethod ? SU_M1 : SU_M0;
          first_nxt = 1'b1;
        end
      end
      SU_M0: begin
        if (suEval) begin
          first_nxt = 1'b0;
          if (sampleIn.offset > offThr ||
              (sampleIn.offset == offThr && usefulThreshEnable && uAbove)) begin
            prox_nxt = 1'b1;
          end else if (sampleIn.offset < offThr || first_r || !usefulThreshEnable ||
                       uBelow) begin
            prox_nxt  = 1'b0;
            state_nxt = SU_IDLE;
          end
        end
      end
      SU_M1: begin
        if (suEval) begin
          first_nxt = 1'b0;
          if (uAbove) begin
            prox_nxt = 1'b1;
          end else if (first_r || uBelow) begin
            prox_nxt    = 1'b0;
            compReq_nxt = !first_r;
            state_nxt   = SU_IDLE;
          end
        end
      end
      default: state_nxt = SU_IDLE;
    endcase
  end
  sample_t outS_nxt;
  always_comb begin
    outS_nxt         = sampleIn;
    outS_nxt.useful  = corrUseful;
    outS_nxt.average = corrAvg;
    if (!sampleValid) begin
      outS_nxt = sampleOut;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r        <= SU_IDLE;
      prox_r         <= 1'b0;
      first_r        <= 1'b0;
      compReq_r      <= 1'b0;
      sampleOut      <= '0;
      sampleOutValid <= 1'b0;
    end else begin
      state_r        <= state_nxt;
      prox_r         <= prox_nxt;
      first_r        <= first_nxt;
      compReq_r      <= compReq_nxt;
      sampleOutValid <= sampleValid;
      sampleOut      <= outS_nxt;
    end
  end
  assign proximityStatus  = prox_r;
  assign compRequest      = compReq_r;
  // offset stays forced for the whole method-1 check; leaving it restores the original
  assign offsetForce      = (state_r == SU_M1);
  assign offsetForceValue = offThr;
  assign avgHold          = (state_r == SU_M1);
  disabledPass_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sampleValid && !ref_correct_enable |=> sampleOut.useful == $past(sampleIn.useful)
      && sampleOut.average == $past(sampleIn.average))
    else $error("disabled correction altered a sample");
  refPhaseRaw_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sampleValid && ref_correct_enable && isRef |=> sampleOut.useful == $past(sampleIn.useful))
    else $error("reference phase was corrected");
  coefZeroPass_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sampleValid && ref_correct_enable && !ref_correct_method && coef == 8'h00
      |=> sampleOut.useful == $past(sampleIn.useful))
    else $error("zero coefficient changed useful value");
  baseFromCal_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    compDone && !ref_baseline_init && suEnabled && suOffset_r == offThr
      |=> refBase_r == $signed({$past(calHigh_r), $past(calLow_r)}))
    else $error("baseline not loaded from calibration");
  baseFromRef_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    compDone && ref_baseline_init |=> refBase_r == $past(curRef))
    else $error("baseline not loaded from reference");
  freqGate_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_r == SU_IDLE && compDone && !suFreq && !compFromPhaseEnable
      |=> state_r == SU_IDLE)
    else $error("start-up ran without phase-enable compensation");
  zeroThrIdle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_r == SU_IDLE && offThr == 6'h00 |=> state_r == SU_IDLE)
    else $error("start-up ran with zero offset threshold");
  m0Set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_r == SU_M0 && suEval && sampleIn.offset > offThr
      |=> proximityStatus && state_r == SU_M0)
    else $error("offset above threshold did not set status");
  m0Clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_r == SU_M0 && suEval && sampleIn.offset < offThr
      |=> !proximityStatus && state_r == SU_IDLE)
    else $error("offset below threshold did not clear status");
  m1Hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_r == SU_IDLE && compDone && suEnabled && suMethod && (suFreq || compFromPhaseEnable)
      |=> offsetForce && avgHold && offsetForceValue == offThr)
    else $error("method 1 check without forced offset");
  m1Fail_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_r == SU_M1 && suEval && first_r && !uAbove
      |=> !proximityStatus && !offsetForce)
    else $error("failed start-up kept status or offset");
endmodule : prox_ref_startup
`default_nettype wire

// *** rtl/prox_ref_consts.svh ***
/*
  Offsets, field positions and reset values of the reference-correction
  and start-up detection stage. Included by the core only.
*/
`ifndef PROX_REF_CONSTS_SVH
`define PROX_REF_CONSTS_SVH
`define OFS_REF_CAL_HIGH     8'h40
`define OFS_REF_CAL_LOW      8'h41
`define OFS_REF_CTRL         8'h42
`define OFS_COEF_LOW_PAIR    8'h43
`define OFS_COEF_HIGH_PAIR   8'h44
`define OFS_STARTUP_CTRL     8'h45
`define OFS_OFFSET_THRESH    8'h46
`define RST_REF_CAL          8'h00
`define RST_REF_CTRL         8'h00
`define RST_COEF             8'h00
`define RST_STARTUP_CTRL     8'h05
`define RST_OFFSET_THRESH    8'h00
`define BIT_REF_EN           4
`define BIT_REF_METHOD       3
`define POS_REF_PHASE        1
`define BIT_REF_INIT         0
`define POS_STARTUP_PHASE    2
`define BIT_STARTUP_FREQ     1
`define BIT_STARTUP_METHOD   0
`define COEF_FRAC_BITS       5
`endif

// *** rtl/prox_ref_pkg.sv ***
/*
  Types of the reference-correction and start-up detection stage.
  Assumes nothing beyond the constants header.
*/
package prox_ref_pkg;
  typedef struct packed {
    logic [1:0]         phase;
    logic signed [15:0] useful;
    logic signed [15:0] average;
    logic [5:0]         offset;
  } sample_t;
  typedef enum logic [1:0] {SU_IDLE, SU_M0, SU_M1} su_state_t;
endpackage : prox_ref_pkg

// *** testbench/prox_host_model.sv ***
/*
  Host-side model of the register port: one write task, one read task.
  Assumes the decoded register port of the stage, everything on clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
module prox_host_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] regRdata,
  output var  logic       regWrite,
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWdata
);
  initial begin
    regWrite = 1'b0;
    regAddr  = 8'h00;
    regWdata = 8'h00;
  end

  // strobe stays up across exactly one taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) #1;
    regWrite = 1'b1;
    regAddr  = a;
    regWdata = d;
    @(posedge clk_sys) #1;
    regWrite = 1'b0;
  endtask : wr

  // read data is combinational, taken at the next edge once settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys) #1;
    regAddr = a;
    @(posedge clk_sys);
    d = regRdata;
  endtask : rd
endmodule : prox_host_model
`default_nettype wire

// *** testbench/tb_prox_ref_startup.sv ***
/*
  Self-checking bench of the reference-correction and start-up stage.
  Assumes the host model owns the register port; samples and
  compensation events are driven by tasks here.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_prox_ref_startup
  import prox_ref_pkg::*;
;
  logic        clk_sys             = 1'b0;
  logic        rst_b               = 1'b0;
  logic        sampleValid         = 1'b0;
  sample_t     sampleIn            = '0;
  logic        compDone            = 1'b0;
  logic        compFromPhaseEnable = 1'b0;
  logic [2:0]  rawFilter           = 3'h0;
  logic        avgFrozen           = 1'b0;
  logic        usefulThreshEnable  = 1'b0;
  logic [15:0] usefulThreshold     = 16'h0000;
  logic        regWrite;
  logic [7:0]  regAddr, regWdata, regRdata;
  sample_t     sampleOut;
  logic        sampleOutValid, proximityStatus, offsetForce, avgHold, compRequest;
  logic [5:0]  offsetForceValue;
  int          mismatches          = 0;
  int          testsRun            = 0;
  int          cycles              = 0;

  prox_ref_startup i_prox_ref_startup (.clk_sys, .rst_b, .regWrite, .regAddr, .regWdata,
    .regRdata, .sampleValid, .sampleIn, .compDone, .compFromPhaseEnable, .rawFilter,
    .avgFrozen, .usefulThreshEnable, .usefulThreshold, .sampleOut, .sampleOutValid,
    .proximityStatus, .offsetForce, .offsetForceValue, .avgHold, .compRequest);
  prox_host_model i_prox_host_model (.clk_sys, .regRdata, .regWrite, .regAddr, .regWdata);

  always #25 clk_sys = ~clk_sys;

  // whole run is well under a thousand cycles; this only catches a hang
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      reportAndStop();
    end
  end

  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : reportAndStop

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_prox_host_model.wr(a, d);
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_prox_host_model.rd(a, d);
    `CHK("regRdata", e, d)
  endtask : rdChk

  task automatic send(input logic [1:0] ph, input logic [15:0] u, input logic [15:0] a,
                      input logic [5:0] o);
    @(posedge clk_sys) #1;
    sampleIn    = '{phase: ph, useful: u, average: a, offset: o};
    sampleValid = 1'b1;
    @(posedge clk_sys) #1;
    sampleValid = 1'b0;
  endtask : send

  task automatic comp(input logic pe);
    @(posedge clk_sys) #1;
    compDone            = 1'b1;
    compFromPhaseEnable = pe;
    @(posedge clk_sys) #1;
    compDone            = 1'b0;
  endtask : comp

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  initial begin
    repeat (4) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rdChk(8'h40 + 8'(i), (i == 5) ? 8'h05 : 8'h00);
    end
    wr(8'h42, 8'hFF);
    wr(8'h45, 8'hFF);
    wr(8'h46, 8'hFF);
    wr(8'h40, 8'hA5);
    wr(8'h50, 8'h77);
    rdChk(8'h42, 8'h1F);
    rdChk(8'h45, 8'h0F);
    rdChk(8'h46, 8'h3F);
    rdChk(8'h40, 8'hA5);
    rdChk(8'h50, 8'h00);
    wr(8'h40, 8'h00);
    wr(8'h45, 8'h05);
    wr(8'h46, 8'h00);
    done("registers");
    wr(8'h43, 8'h20);
    wr(8'h44, 8'h20);
    for (int r = 0; r < 4; r++) begin
      wr(8'h42, 8'h11 | 8'(r << 1));
      send(2'(r), 16'h0064, 16'h0000, 6'h00);
      comp(1'b0);
      send(2'(r), 16'h0084, 16'h0000, 6'h00);
      `CHK("refUseful", 16'h0084, sampleOut.useful)
      send(2'(r + 1), 16'h03E8, 16'h0000, 6'h00);
      `CHK("useful", 16'h03C8, sampleOut.useful)
    end
    wr(8'h43, 8'h01);
    send(2'h0, 16'h03E8, 16'h0000, 6'h00);
    `CHK("useful", 16'h03E7, sampleOut.useful)
    wr(8'h44, 8'h40);
    send(2'h2, 16'h03E8, 16'h0000, 6'h00);
    `CHK("useful", 16'h03A8, sampleOut.useful)
    rawFilter = 3'h1;
    send(2'h2, 16'h03E8, 16'h0000, 6'h00);
    `CHK("useful", 16'h03C8, sampleOut.useful)
    rawFilter = 3'h0;
    wr(8'h42, 8'h06);
    send(2'h2, 16'h03E8, 16'h0000, 6'h00);
    `CHK("useful", 16'h03E8, sampleOut.useful)
    `CHK("sampleOutValid", 1'b1, sampleOutValid)
    done("method0 correction");
    wr(8'h41, 8'h64);
    `CHK("sampleOutValid", 1'b0, sampleOutValid)
    wr(8'h46, 8'h05);
    wr(8'h42, 8'h10);
    send(2'h1, 16'h0000, 16'h0000, 6'h05);
    send(2'h0, 16'h012C, 16'h0000, 6'h00);
    comp(1'b0);
    send(2'h2, 16'h03E8, 16'h0000, 6'h00);
    `CHK("useful", 16'h0258, sampleOut.useful)
    wr(8'h42, 8'h11);
    comp(1'b0);
    send(2'h2, 16'h03E8, 16'h0000, 6'h00);
    `CHK("useful", 16'h03E8, sampleOut.useful)
    done("baseline");
    wr(8'h45, 8'h04);
    wr(8'h43, 8'h20);
    usefulThreshEnable = 1'b1;
    usefulThreshold    = 16'h0032;
    send(2'h0, 16'h0064, 16'h0000, 6'h00);
    comp(1'b1);
    send(2'h0, 16'h00C8, 16'h0000, 6'h00);
    send(2'h1, 16'h0078, 16'h0000, 6'h05);
    `CHK("useful", 16'h0014, sampleOut.useful)
    `CHK("proximityStatus", 1'b0, proximityStatus)
    wr(8'h42, 8'h00);
    comp(1'b0);
    send(2'h1, 16'h0000, 16'h0000, 6'h06);
    `CHK("proximityStatus", 1'b0, proximityStatus)
    comp(1'b1);
    send(2'h1, 16'h003C, 16'h0000, 6'h06);
    `CHK("proximityStatus", 1'b1, proximityStatus)
    send(2'h1, 16'h003C, 16'h0000, 6'h05);
    `CHK("proximityStatus", 1'b1, proximityStatus)
    send(2'h1, 16'h0028, 16'h0000, 6'h05);
    `CHK("proximityStatus", 1'b0, proximityStatus)
    send(2'h1, 16'h0000, 16'h0000, 6'h07);
    `CHK("proximityStatus", 1'b0, proximityStatus)
    comp(1'b1);
    send(2'h1, 16'h003C, 16'h0000, 6'h05);
    `CHK("proximityStatus", 1'b1, proximityStatus)
    send(2'h1, 16'h0000, 16'h0000, 6'h03);
    `CHK("proximityStatus", 1'b0, proximityStatus)
    wr(8'h45, 8'h06);
    comp(1'b0);
    send(2'h1, 16'h0000, 16'h0000, 6'h09);
    `CHK("proximityStatus", 1'b1, proximityStatus)
    send(2'h1, 16'h0000, 16'h0000, 6'h02);
    done("start-up method0");
    wr(8'h45, 8'h05);
    comp(1'b1);
    `CHK("offsetForce", 1'b1, offsetForce)
    `CHK("avgHold", 1'b1, avgHold)
    `CHK("offsetForceValue", 6'h05, offsetForceValue)
    send(2'h1, 16'h003C, 16'h0000, 6'h00);
    `CHK("proximityStatus", 1'b1, proximityStatus)
    send(2'h1, 16'h0028, 16'h0000, 6'h00);
    `CHK("proximityStatus", 1'b0, proximityStatus)
    `CHK("compRequest", 1'b1, compRequest)
    `CHK("offsetForce", 1'b0, offsetForce)
    comp(1'b1);
    send(2'h1, 16'h0028, 16'h0000, 6'h00);
    `CHK("proximityStatus", 1'b0, proximityStatus)
    `CHK("compRequest", 1'b0, compRequest)
    `CHK("avgHold", 1'b0, avgHold)
    done("start-up method1");
    wr(8'h42, 8'h18);
    send(2'h0, 16'h0064, 16'h0000, 6'h00);
    avgFrozen = 1'b1;
    send(2'h1, 16'h0000, 16'h01F4, 6'h00);
    `CHK("average", 16'h01F4, sampleOut.average)
    send(2'h0, 16'h0096, 16'h0000, 6'h00);
    send(2'h1, 16'h0000, 16'h03E7, 6'h00);
    `CHK("average", 16'h0226, sampleOut.average)
    avgFrozen = 1'b0;
    done("method1 correction");
    reportAndStop();
  end
endmodule : tb_prox_ref_startup
`default_nettype wire
